// ===== hdl/aao_core.sv
// Execute logic for the accumulator group of a 4-bit core.
// Assumes instructions arrive one per op_valid pulse, synchronous
// to clock, and that ROM data comes back on rom_valid.
//
// Notes on behaviour
// - A load-immediate writes the immediate nibble into the accumulator.
// - In a direct run of load-immediates only the first executes; the rest are idle.
// - A table lookup with the high-bits select clear puts ROM bits 7..4 in B and 3..0 in A.
// - With the high-bits select set, the lookup also puts ROM bits 9..8 into register D.
// - The lookup address is D[2:0] then A[3:0] inside the page given by the operand.
// - A lookup holds one return-stack level while it runs; software keeps the stack from overflowing.
// - Add-memory adds the pointed nibble to A and leaves carry alone.
// - Add-with-carry adds the nibble and carry to A and writes carry-out to carry.
// - Add-immediate adds the immediate to A and leaves carry alone.
// - After add-immediate the next instruction is skipped unless the sum overflowed.
// - AND-memory writes A AND the pointed nibble into A.
// - OR-memory writes A OR the pointed nibble into A.
// - Set-carry forces carry to one, clear-carry forces it to zero, nothing else moves.
// - Skip-on-no-carry skips the next instruction when carry is zero.
`timescale 1ns/1ps
`default_nettype none
module aao_core (
  input  wire logic                          clock,
  input  wire logic                          rstn,
  input  wire logic                          op_valid,
  input  wire aao_pkg::aao_op_type           op_code,
  input  wire logic [aao_pkg::NIB_W-1:0]     imm,
  input  wire logic [aao_pkg::PAGE_W-1:0]    table_page,
  input  wire logic [aao_pkg::NIB_W-1:0]     mem_data,
  input  wire logic                          table_high_bits_select,
  input  wire logic [aao_pkg::ROM_W-1:0]     rom_data,
  input  wire logic                          rom_valid,
  input  wire logic                          reg_d_wr,
  input  wire logic [aao_pkg::D_W-1:0]       reg_d_wr_data,
  output logic [aao_pkg::NIB_W-1:0]          acc,
  output logic [aao_pkg::NIB_W-1:0]          reg_b,
  output logic [aao_pkg::D_W-1:0]            reg_d,
  output logic                               carry_flag,
  output logic                               skip_next,
  output logic                               op_idle,
  output logic                               lookup_busy,
  output logic                               rom_req,
  output logic [aao_pkg::ADDR_W-1:0]         rom_addr,
  output logic                               stack_push,
  output logic                               stack_pop
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  aao_pkg::aao_state_type          state_r;
  logic [aao_pkg::NIB_W-1:0]       acc_r;
  logic [aao_pkg::NIB_W-1:0]       b_r;
  logic [aao_pkg::D_W-1:0]         d_r;
  logic                            cy_r;
  logic                            skip_next_r;
  logic                            last_li_r;
  logic                            op_idle_r;
  logic                            lookup_busy_r;
  logic                            rom_req_r;
  logic [aao_pkg::ADDR_W-1:0]      rom_addr_r;
  logic                            hi_sel_r;
  logic                            stack_push_r;
  logic                            stack_pop_r;

  // ----------------------------------------------------------------
  // Slot decode
  // ----------------------------------------------------------------
  logic slot_take;
  logic li_repeat;
  logic slot_idle;
  logic exec;
  logic tab_done;
  logic skip_nxt;

  // Instructions are ignored while a lookup waits for ROM
  assign slot_take = op_valid && (state_r == aao_pkg::ST_RUN);
  assign li_repeat = (op_code == aao_pkg::OP_LOAD_IMM) && last_li_r;
  assign slot_idle = skip_next_r || li_repeat;
  assign exec      = slot_take && !slot_idle;
  assign tab_done  = (state_r == aao_pkg::ST_TAB_WAIT) && rom_valid;

  // ----------------------------------------------------------------
  // ALU
  // ----------------------------------------------------------------
  aao_alu_if alu_bus ();

  // Feed the ALU only with executing ops, so idle slots compute nothing
  assign alu_bus.op  = exec ? op_code : aao_pkg::OP_NONE;
  assign alu_bus.a   = acc_r;
  assign alu_bus.m   = mem_data;
  assign alu_bus.imm = imm;
  assign alu_bus.cy  = cy_r;

  aao_alu u_alu (
    .bus (alu_bus.alu)
  );

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------

  // Lookup waits here; the ROM side may take any number of cycles
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_r <= aao_pkg::ST_RUN;
    end else begin
      unique case (state_r)
        aao_pkg::ST_RUN: begin
          if (exec && op_code == aao_pkg::OP_TABLE) begin
            state_r <= aao_pkg::ST_TAB_WAIT;
          end
        end
        aao_pkg::ST_TAB_WAIT: begin
          if (rom_valid) begin
            state_r <= aao_pkg::ST_RUN;
          end
        end
      endcase
    end
  end

  // Run tracking: any taken slot, executed or not, updates it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      last_li_r <= 1'b0;
    end else if (slot_take) begin
      last_li_r <= (op_code == aao_pkg::OP_LOAD_IMM);
    end
  end

  // Skip decision for the following slot
  always_comb begin
    skip_nxt = 1'b0;
    if (exec && op_code == aao_pkg::OP_ADD_IMM) begin
      skip_nxt = !alu_bus.ovf;
    end
    if (exec && op_code == aao_pkg::OP_SKIP_NO_CARRY) begin
      skip_nxt = !cy_r;
    end
  end

  // A pending skip is spent by the next taken slot
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      skip_next_r <= 1'b0;
    end else if (slot_take) begin
      skip_next_r <= skip_nxt;
    end
  end

  // Pulse for each slot consumed without effect
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      op_idle_r <= 1'b0;
    end else begin
      op_idle_r <= slot_take && slot_idle;
    end
  end

  // ----------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------

  // Accumulator: lookup data wins, it cannot meet an executing op
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      acc_r <= aao_pkg::ACC_RST;
    end else if (tab_done) begin
      acc_r <= rom_data[aao_pkg::ROM_LO_LSB +: aao_pkg::NIB_W];
    end else if (exec) begin
      acc_r <= alu_bus.res;
    end
  end

  // Carry changes only where the ALU says so
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cy_r <= aao_pkg::CY_RST;
    end else if (exec) begin
      cy_r <= alu_bus.cy_out;
    end
  end

  // Register B is loaded only by the lookup
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      b_r <= aao_pkg::B_RST;
    end else if (tab_done) begin
      b_r <= rom_data[aao_pkg::ROM_MID_LSB +: aao_pkg::NIB_W];
    end
  end

  // Register D: lookup high bits beat a write from outside
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      d_r <= aao_pkg::D_RST;
    end else if (tab_done && hi_sel_r) begin
      d_r[aao_pkg::ROM_HI_W-1:0] <= rom_data[aao_pkg::ROM_HI_LSB +: aao_pkg::ROM_HI_W];
    end else if (reg_d_wr) begin
      d_r <= reg_d_wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Table lookup
  // ----------------------------------------------------------------

  // Address and select are frozen at issue, so later D or A changes
  // cannot bend a lookup in flight
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rom_addr_r <= aao_pkg::ADDR_RST;
      hi_sel_r   <= 1'b0;
    end else if (exec && op_code == aao_pkg::OP_TABLE) begin
      rom_addr_r <= {table_page, d_r, acc_r};
      hi_sel_r   <= table_high_bits_select;
    end
  end

  // One-cycle request strobe
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rom_req_r <= 1'b0;
    end else begin
      rom_req_r <= exec && (op_code == aao_pkg::OP_TABLE);
    end
  end

  // Stack level held for the whole lookup; no guard on a full stack
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stack_push_r  <= 1'b0;
      stack_pop_r   <= 1'b0;
      lookup_busy_r <= 1'b0;
    end else begin
      stack_push_r <= exec && (op_code == aao_pkg::OP_TABLE);
      stack_pop_r  <= tab_done;
      if (exec && op_code == aao_pkg::OP_TABLE) begin
        lookup_busy_r <= 1'b1;
      end else if (tab_done) begin
        lookup_busy_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign acc         = acc_r;
  assign reg_b       = b_r;
  assign reg_d       = d_r;
  assign carry_flag  = cy_r;
  assign skip_next   = skip_next_r;
  assign op_idle     = op_idle_r;
  assign lookup_busy = lookup_busy_r;
  assign rom_req     = rom_req_r;
  assign rom_addr    = rom_addr_r;
  assign stack_push  = stack_push_r;
  assign stack_pop   = stack_pop_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  logic go_run;
  assign go_run = op_valid && !lookup_busy_r && !skip_next_r;

  sequence seq_tab_issue;
    go_run && op_code == aao_pkg::OP_TABLE;
  endsequence

  sequence seq_tab_done;
    lookup_busy_r && rom_valid;
  endsequence

  chk_li_load: assert property (go_run && op_code == aao_pkg::OP_LOAD_IMM && !last_li_r
    |=> acc_r == $past(imm)) else $error("load immediate wrong");
  chk_li_run_idle: assert property (go_run && op_code == aao_pkg::OP_LOAD_IMM && last_li_r
    |=> $stable(acc_r) && op_idle_r) else $error("repeated load not idle");
  chk_tab_low: assert property (seq_tab_done and !hi_sel_r
    |=> acc_r == $past(rom_data[3:0]) && b_r == $past(rom_data[7:4])) else $error("lookup low bad");
  chk_tab_high: assert property (seq_tab_done and hi_sel_r
    |=> d_r[1:0] == $past(rom_data[9:8]) && b_r == $past(rom_data[7:4])) else $error("lookup high bad");
  chk_tab_addr: assert property (seq_tab_issue
    |=> rom_req_r && rom_addr_r == $past({table_page, d_r, acc_r})) else $error("lookup address bad");
  chk_tab_stack: assert property (seq_tab_issue |=> stack_push_r && lookup_busy_r
    ##0 (lookup_busy_r && !stack_pop_r) [*1]) else $error("stack not held");
  chk_tab_release: assert property (seq_tab_done
    |=> stack_pop_r && !lookup_busy_r) else $error("stack not released");
  chk_add_mem: assert property (go_run && op_code == aao_pkg::OP_ADD_MEM
    |=> acc_r == $past(acc_r + mem_data) && $stable(cy_r)) else $error("add memory bad");
  chk_add_carry: assert property (go_run && op_code == aao_pkg::OP_ADD_CARRY_MEM
    |=> {cy_r, acc_r} == $past({1'b0, acc_r} + {1'b0, mem_data} + {4'h0, cy_r})) else $error("adc bad");
  chk_add_imm: assert property (go_run && op_code == aao_pkg::OP_ADD_IMM
    |=> acc_r == $past(acc_r + imm) && $stable(cy_r)) else $error("add immediate bad");
  chk_add_skip: assert property (go_run && op_code == aao_pkg::OP_ADD_IMM
    |=> skip_next_r == ($past({1'b0, acc_r} + {1'b0, imm}) <= 5'h0F)) else $error("add skip bad");
  chk_and_mem: assert property (go_run && op_code == aao_pkg::OP_AND_MEM
    |=> acc_r == $past(acc_r & mem_data)) else $error("and bad");
  chk_or_mem: assert property (go_run && op_code == aao_pkg::OP_OR_MEM
    |=> acc_r == $past(acc_r | mem_data)) else $error("or bad");
  chk_carry_set: assert property (go_run && op_code == aao_pkg::OP_SET_CARRY
    |=> cy_r && $stable(acc_r) && $stable(b_r)) else $error("set carry bad");
  chk_carry_clr: assert property (go_run && op_code == aao_pkg::OP_CLR_CARRY
    |=> !cy_r && $stable(acc_r) && $stable(b_r)) else $error("clear carry bad");
  chk_skip_carry: assert property (go_run && op_code == aao_pkg::OP_SKIP_NO_CARRY
    |=> skip_next_r == !$past(cy_r)) else $error("carry skip bad");
  chk_idle_slot: assert property (op_valid && !lookup_busy_r && skip_next_r
    |=> $stable(acc_r) && $stable(cy_r) && $stable(b_r)
    && op_idle_r && !skip_next_r) else $error("skip slot moved");

endmodule
`default_nettype wire

// ===== include/aao_pkg.sv
// Shared constants and types for the accumulator ALU group.
// Assumes a 4-bit core with 10-bit ROM words and 64 table pages.
`default_nettype none
package aao_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int NIB_W  = 4;
  localparam int ROM_W  = 10;
  localparam int PAGE_W = 6;
  localparam int D_W    = 3;
  localparam int ADDR_W = PAGE_W + D_W + NIB_W;

  // ----------------------------------------------------------------
  // ROM word field positions
  // ----------------------------------------------------------------
  localparam int ROM_LO_LSB  = 0;
  localparam int ROM_MID_LSB = 4;
  localparam int ROM_HI_LSB  = 8;
  localparam int ROM_HI_W    = 2;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [NIB_W-1:0]  ACC_RST  = 4'h0;
  localparam logic [NIB_W-1:0]  B_RST    = 4'h0;
  localparam logic [D_W-1:0]    D_RST    = 3'h0;
  localparam logic              CY_RST   = 1'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;

  // ----------------------------------------------------------------
  // Operations handled here
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE,
    OP_LOAD_IMM,
    OP_TABLE,
    OP_ADD_MEM,
    OP_ADD_CARRY_MEM,
    OP_ADD_IMM,
    OP_AND_MEM,
    OP_OR_MEM,
    OP_SET_CARRY,
    OP_CLR_CARRY,
    OP_SKIP_NO_CARRY
  } aao_op_type;

  typedef enum logic {
    ST_RUN,
    ST_TAB_WAIT
  } aao_state_type;

endpackage
`default_nettype wire

// ===== include/aao_alu_if.sv
// Carrier between the core and its combinational ALU.
// Assumes both ends sit in one clock domain; no timing of its own.
`timescale 1ns/1ps
`default_nettype none
interface aao_alu_if;
  aao_pkg::aao_op_type         op;
  logic [aao_pkg::NIB_W-1:0]   a;
  logic [aao_pkg::NIB_W-1:0]   m;
  logic [aao_pkg::NIB_W-1:0]   imm;
  logic                        cy;
  logic [aao_pkg::NIB_W-1:0]   res;
  logic                        cy_out;
  logic                        ovf;

  modport core (output op, a, m, imm, cy, input res, cy_out, ovf);
  modport alu  (input op, a, m, imm, cy, output res, cy_out, ovf);
endinterface
`default_nettype wire

// ===== hdl/aao_alu.sv
// Combinational 4-bit ALU for the accumulator operation group.
// Assumes the core registers every result; nothing here is clocked.
`timescale 1ns/1ps
`default_nettype none
module aao_alu (
  aao_alu_if.alu bus
);

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  logic [aao_pkg::NIB_W:0] sum5;
  logic [aao_pkg::NIB_W-1:0] rhs;
  logic                      cin;

  // Operand and carry-in selection
  always_comb begin
    rhs = bus.m;
    cin = 1'b0;
    if (bus.op == aao_pkg::OP_ADD_IMM) begin
      rhs = bus.imm;
    end
    if (bus.op == aao_pkg::OP_ADD_CARRY_MEM) begin
      cin = bus.cy;
    end
    sum5 = {1'b0, bus.a} + {1'b0, rhs} + {4'h0, cin};
  end

  // Result and flag selection
  always_comb begin
    bus.res    = bus.a;
    bus.cy_out = bus.cy;
    bus.ovf    = sum5[aao_pkg::NIB_W]; // Above 15 means overflow
    unique case (bus.op)
      aao_pkg::OP_LOAD_IMM:      bus.res = bus.imm;
      aao_pkg::OP_ADD_MEM:       bus.res = sum5[aao_pkg::NIB_W-1:0];
      aao_pkg::OP_ADD_IMM:       bus.res = sum5[aao_pkg::NIB_W-1:0];
      aao_pkg::OP_ADD_CARRY_MEM: begin
        bus.res    = sum5[aao_pkg::NIB_W-1:0];
        bus.cy_out = sum5[aao_pkg::NIB_W];
      end
      aao_pkg::OP_AND_MEM:       bus.res = bus.a & bus.m;
      aao_pkg::OP_OR_MEM:        bus.res = bus.a | bus.m;
      aao_pkg::OP_SET_CARRY:     bus.cy_out = 1'b1;
      aao_pkg::OP_CLR_CARRY:     bus.cy_out = 1'b0;
      default: begin
        bus.res    = bus.a;
        bus.cy_out = bus.cy;
      end
    endcase
  end

endmodule
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the accumulator ALU group core.
// Assumes aao_pkg, aao_alu_if, aao_alu and aao_core are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic                              clock;
  logic                              rstn;
  logic                              op_valid;
  aao_pkg::aao_op_type               op_code;
  logic [aao_pkg::NIB_W-1:0]         imm;
  logic [aao_pkg::PAGE_W-1:0]        table_page;
  logic [aao_pkg::NIB_W-1:0]         mem_data;
  logic                              table_high_bits_select;
  logic [aao_pkg::ROM_W-1:0]         rom_data;
  logic                              rom_valid;
  logic                              reg_d_wr;
  logic [aao_pkg::D_W-1:0]           reg_d_wr_data;
  logic [aao_pkg::NIB_W-1:0]         acc;
  logic [aao_pkg::NIB_W-1:0]         reg_b;
  logic [aao_pkg::D_W-1:0]           reg_d;
  logic                              carry_flag;
  logic                              skip_next;
  logic                              op_idle;
  logic                              lookup_busy;
  logic                              rom_req;
  logic [aao_pkg::ADDR_W-1:0]        rom_addr;
  logic                              stack_push;
  logic                              stack_pop;
  int                                n_errors;
  int                                checks_done;

  aao_core aao_core_i (
    .clock                  (clock),
    .rstn                   (rstn),
    .op_valid               (op_valid),
    .op_code                (op_code),
    .imm                    (imm),
    .table_page             (table_page),
    .mem_data               (mem_data),
    .table_high_bits_select (table_high_bits_select),
    .rom_data               (rom_data),
    .rom_valid              (rom_valid),
    .reg_d_wr               (reg_d_wr),
    .reg_d_wr_data          (reg_d_wr_data),
    .acc                    (acc),
    .reg_b                  (reg_b),
    .reg_d                  (reg_d),
    .carry_flag             (carry_flag),
    .skip_next              (skip_next),
    .op_idle                (op_idle),
    .lookup_busy            (lookup_busy),
    .rom_req                (rom_req),
    .rom_addr               (rom_addr),
    .stack_push             (stack_push),
    .stack_pop              (stack_pop)
  );

  // Free-running 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ---------------------------------------------------------------
  // Compare and report helpers
  // ---------------------------------------------------------------
  task automatic check_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %0b, seen %0b", what, exp, got);
    end
  endtask

  task automatic check_nib(input string what, input logic [3:0] exp, input logic [3:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic check_addr(input string what, input logic [12:0] exp, input logic [12:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Core state after an instruction slot
  task automatic expect_core(input logic [3:0] a, input logic c, input logic s, input logic i);
    check_nib("acc", a, acc);
    check_bit("carry_flag", c, carry_flag);
    check_bit("skip_next", s, skip_next);
    check_bit("op_idle", i, op_idle);
  endtask

  // ---------------------------------------------------------------
  // Drivers
  // ---------------------------------------------------------------
  // One slot; returns just after the taking edge so results have landed
  task automatic slot(input aao_pkg::aao_op_type op, input logic [3:0] n, input logic [3:0] m);
    @(posedge clock);
    op_valid <= 1'b1;
    op_code  <= op;
    imm      <= n;
    mem_data <= m;
    @(posedge clock);
    op_valid <= 1'b0;
    op_code  <= aao_pkg::OP_NONE;
    imm      <= ~n;
    mem_data <= ~m;
    #1;
  endtask

  task automatic set_d(input logic [2:0] d);
    @(posedge clock);
    reg_d_wr      <= 1'b1;
    reg_d_wr_data <= d;
    @(posedge clock);
    reg_d_wr      <= 1'b0;
    reg_d_wr_data <= ~d;
    #1;
    check_nib("reg_d", {1'b0, d}, {1'b0, reg_d});
  endtask

  // Lookup with a refused slot offered in the same cycle as the ROM answer
  task automatic lookup(input logic sel, input logic [5:0] page, input logic [12:0] exp_addr,
                        input logic [9:0] word);
    int n;
    @(posedge clock);
    table_high_bits_select <= sel;
    table_page             <= page;
    slot(aao_pkg::OP_TABLE, 4'h0, 4'h0);
    check_bit("rom_req", 1'b1, rom_req);
    check_addr("rom_addr", exp_addr, rom_addr);
    check_bit("stack_push", 1'b1, stack_push);
    check_bit("lookup_busy", 1'b1, lookup_busy);
    @(posedge clock);
    rom_valid <= 1'b1;
    rom_data  <= word;
    op_valid  <= 1'b1;
    op_code   <= aao_pkg::OP_LOAD_IMM;
    imm       <= ~word[3:0];
    @(posedge clock);
    rom_valid <= 1'b0;
    rom_data  <= ~word;
    op_valid  <= 1'b0;
    op_code   <= aao_pkg::OP_NONE;
    #1;
    n = 0;
    while (lookup_busy !== 1'b0 && n < 8) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (lookup_busy !== 1'b0) begin
      n_errors++;
      $display("unexpected lookup_busy: expected 0, seen 1");
      summarize();
    end
    check_bit("stack_pop", 1'b1, stack_pop);
    check_bit("op_idle", 1'b0, op_idle);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    expect_core(4'h0, 1'b0, 1'b0, 1'b0);
    check_nib("reg_b", 4'h0, reg_b);
    check_bit("lookup_busy", 1'b0, lookup_busy);
    $display("test reset finished");
  endtask

  task automatic t_load_run();
    slot(aao_pkg::OP_LOAD_IMM, 4'h5, 4'h0);
    expect_core(4'h5, 1'b0, 1'b0, 1'b0);
    slot(aao_pkg::OP_LOAD_IMM, 4'h9, 4'h0);
    expect_core(4'h5, 1'b0, 1'b0, 1'b1);
    slot(aao_pkg::OP_LOAD_IMM, 4'hA, 4'h0);
    expect_core(4'h5, 1'b0, 1'b0, 1'b1);
    slot(aao_pkg::OP_NONE, 4'h0, 4'h0);
    expect_core(4'h5, 1'b0, 1'b0, 1'b0);
    slot(aao_pkg::OP_LOAD_IMM, 4'h3, 4'h0);
    expect_core(4'h3, 1'b0, 1'b0, 1'b0);
    $display("test load_run finished");
  endtask

  task automatic t_add_mem();
    slot(aao_pkg::OP_SET_CARRY, 4'h0, 4'h0);
    expect_core(4'h3, 1'b1, 1'b0, 1'b0);
    slot(aao_pkg::OP_ADD_MEM, 4'h0, 4'hE);
    expect_core(4'h1, 1'b1, 1'b0, 1'b0);
    slot(aao_pkg::OP_CLR_CARRY, 4'h0, 4'h0);
    expect_core(4'h1, 1'b0, 1'b0, 1'b0);
    slot(aao_pkg::OP_ADD_CARRY_MEM, 4'h0, 4'hF);
    expect_core(4'h0, 1'b1, 1'b0, 1'b0);
    slot(aao_pkg::OP_ADD_CARRY_MEM, 4'h0, 4'h0);
    expect_core(4'h1, 1'b0, 1'b0, 1'b0);
    $display("test add_mem finished");
  endtask

  task automatic t_add_imm();
    slot(aao_pkg::OP_SET_CARRY, 4'h0, 4'h0);
    expect_core(4'h1, 1'b1, 1'b0, 1'b0);
    slot(aao_pkg::OP_ADD_IMM, 4'h4, 4'h0);
    expect_core(4'h5, 1'b1, 1'b1, 1'b0);
    slot(aao_pkg::OP_ADD_MEM, 4'h0, 4'h7);
    expect_core(4'h5, 1'b1, 1'b0, 1'b1);
    slot(aao_pkg::OP_ADD_IMM, 4'hF, 4'h0);
    expect_core(4'h4, 1'b1, 1'b0, 1'b0);
    slot(aao_pkg::OP_ADD_MEM, 4'h0, 4'h1);
    expect_core(4'h5, 1'b1, 1'b0, 1'b0);
    slot(aao_pkg::OP_ADD_IMM, 4'hA, 4'h0);
    expect_core(4'hF, 1'b1, 1'b1, 1'b0);
    slot(aao_pkg::OP_CLR_CARRY, 4'h0, 4'h0);
    expect_core(4'hF, 1'b1, 1'b0, 1'b1);
    $display("test add_imm finished");
  endtask

  task automatic t_logic();
    slot(aao_pkg::OP_LOAD_IMM, 4'hC, 4'h0);
    expect_core(4'hC, 1'b1, 1'b0, 1'b0);
    slot(aao_pkg::OP_AND_MEM, 4'h0, 4'hA);
    expect_core(4'h8, 1'b1, 1'b0, 1'b0);
    slot(aao_pkg::OP_OR_MEM, 4'h0, 4'h3);
    expect_core(4'hB, 1'b1, 1'b0, 1'b0);
    $display("test logic finished");
  endtask

  task automatic t_skip_carry();
    slot(aao_pkg::OP_CLR_CARRY, 4'h0, 4'h0);
    expect_core(4'hB, 1'b0, 1'b0, 1'b0);
    slot(aao_pkg::OP_SKIP_NO_CARRY, 4'h0, 4'h0);
    expect_core(4'hB, 1'b0, 1'b1, 1'b0);
    slot(aao_pkg::OP_SET_CARRY, 4'h0, 4'h0);
    expect_core(4'hB, 1'b0, 1'b0, 1'b1);
    slot(aao_pkg::OP_SET_CARRY, 4'h0, 4'h0);
    expect_core(4'hB, 1'b1, 1'b0, 1'b0);
    slot(aao_pkg::OP_SKIP_NO_CARRY, 4'h0, 4'h0);
    expect_core(4'hB, 1'b1, 1'b0, 1'b0);
    $display("test skip_carry finished");
  endtask

  task automatic t_table_low();
    set_d(3'h5);
    slot(aao_pkg::OP_LOAD_IMM, 4'h9, 4'h0);
    lookup(1'b0, 6'h2A, {6'h2A, 3'h5, 4'h9}, 10'h3A7);
    check_nib("acc", 4'h7, acc);
    check_nib("reg_b", 4'hA, reg_b);
    check_nib("reg_d", 4'h5, {1'b0, reg_d});
    $display("test table_low finished");
  endtask

  task automatic t_table_high();
    lookup(1'b1, 6'h3F, {6'h3F, 3'h5, 4'h7}, 10'h2C1);
    check_nib("acc", 4'h1, acc);
    check_nib("reg_b", 4'hC, reg_b);
    check_nib("reg_d", 4'h6, {1'b0, reg_d});
    $display("test table_high finished");
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    n_errors               = 0;
    checks_done            = 0;
    rstn                   = 1'b0;
    op_valid               = 1'b0;
    op_code                = aao_pkg::OP_NONE;
    imm                    = 4'h0;
    table_page             = 6'h00;
    mem_data               = 4'h0;
    table_high_bits_select = 1'b0;
    rom_data               = 10'h000;
    rom_valid              = 1'b0;
    reg_d_wr               = 1'b0;
    reg_d_wr_data          = 3'h0;
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    #1;
    t_reset();
    t_load_run();
    t_add_mem();
    t_add_imm();
    t_logic();
    t_skip_carry();
    t_table_low();
    t_table_high();
    summarize();
  end
endmodule
`default_nettype wire
